// *** acl_top.sv ***
// How it works
// - axes 0 and 1 hold five comparators, axes 2 and 3 four; all but comparator 4 have one fixed job and source
// - comparators 1 and 2 check command position against plus and minus soft limits
// - a reached soft limit stops the axis like a limit switch, at once or ramped
// - comparator 3 checks position error against a tolerance, own enable bit
// - enabled out-of-step beyond tolerance raises an interrupt request
// - comparator 4 takes any counter, with programmable value, method and reaction
// - comparator 4 raises an interrupt by default when satisfied
// - only comparator 5 drives the trigger pin
// - trigger comparator exists on axes 0 and 1 and watches feedback position
// - trigger condition is a value plus greater, equal or less mode
// - equal mode pulses once on every match with the current value
// - list mode ignores the single value and uses list entries
// - writing list source 1 selects list mode and starts comparing at once
// - host may read the active compare value at any time
// - one extra entry loads after the last match, host adds a far dummy
// - a latch pulse captures all four counters of the axis together in hardware
// - latching exists only on axes 2 and 3, each with its own pin
// - latch input polarity is programmable
// - latched data is read back per counter number
// - the origin sensor may replace the latch pin as latch source
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module acl_top #(
   parameter int CW    = 28,
   parameter int DEPTH = 64
) (
   input  wire logic                     CORE_CLK_IN,
   input  wire logic                     RSTN_IN,
   input  wire logic                     WB_CYC_IN,
   input  wire logic                     WB_STB_IN,
   input  wire logic                     WB_WE_IN,
   input  wire logic [7:0]               WB_ADR_IN,
   input  wire logic [3:0]               WB_SEL_IN,
   input  wire logic [31:0]              WB_DAT_IN,
   output logic      [31:0]              WB_DAT_OUT,
   output logic                          WB_ACK_OUT,
   input  wire logic [3:0][3:0][CW-1:0]  AXIS_CNT_IN,
   input  wire logic                     LATCH_IN_AXIS_C_IN,
   input  wire logic                     LATCH_IN_AXIS_D_IN,
   input  wire logic [3:0]               ORIGIN_SENSOR_INPUT_IN,
   output wire logic                     TRIGGER_OUT_AXIS_A_OUT,
   output wire logic                     TRIGGER_OUT_AXIS_B_OUT,
   output wire logic [3:0]               STOP_IMM_OUT,
   output wire logic [3:0]               STOP_DEC_OUT,
   output wire logic [3:0]               OOS_REQ_OUT,
   output wire logic [3:0]               GEN_REQ_OUT
);

   localparam int AW = $clog2(DEPTH);
   localparam int PW = $clog2(acl_pkg::TRIG_PULSE_CYC + 1);
   localparam logic [PW-1:0] PULSE_LEN = PW'(acl_pkg::TRIG_PULSE_CYC);

   // ----------------------------------------
   // parameter checks
   // ----------------------------------------
   if (CW < 8 || CW > 31) begin : g_chk_cw
      $error("counter width must be 8 to 31");
   end
   if (DEPTH < 2 || DEPTH > 32768 || (1 << AW) != DEPTH) begin : g_chk_depth
      $error("list depth must be a power of two, 2 to 32768");
   end

   function automatic logic signed [31:0] sx(input logic [CW-1:0] v);
      sx = {{(32-CW){v[CW-1]}}, v};
   endfunction

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   logic        ack_ff;
   logic [31:0] dat_ff;
   wire         wb_hit = WB_CYC_IN & WB_STB_IN & ~ack_ff;
   wire         wr_stb = wb_hit & WB_WE_IN;
   wire [1:0]   ax     = WB_ADR_IN[acl_pkg::AX_LSB +: 2];
   wire [3:0]   rg     = WB_ADR_IN[acl_pkg::RG_LSB +: 4];
   wire [31:0]  wmask  = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}},
                          {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
   wire [3:0][31:0] rd_w;
   wire [31:0]  rd_sel = rd_w[ax];

   function automatic logic [31:0] mrg(input logic [31:0] o);
      mrg = (o & ~wmask) | (WB_DAT_IN & wmask);
   endfunction

   // answer always one cycle after the request; unused offsets read zero
   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
      end else begin
         ack_ff <= wb_hit;
         if (wb_hit && !WB_WE_IN) begin
            dat_ff <= rd_sel;
         end
      end
   end

   assign WB_ACK_OUT = ack_ff;
   assign WB_DAT_OUT = dat_ff;

   // ----------------------------------------
   // cross-axis results
   // ----------------------------------------
   wire [3:0]              trg_ev;
   wire [3:0]              lat_ev;
   wire [3:0]              trg_w;
   wire [3:0][CW-1:0]      act_w;
   wire [3:0][15:0]        cnt_w;
   wire [3:0]              full_w;
   wire [3:0]              empty_w;
   wire [3:0][3:0][CW-1:0] lat_w;
   wire [3:0]              lpin = {LATCH_IN_AXIS_D_IN, LATCH_IN_AXIS_C_IN, 2'b00};

   assign TRIGGER_OUT_AXIS_A_OUT = trg_w[0];
   assign TRIGGER_OUT_AXIS_B_OUT = trg_w[1];

   genvar a;
   for (a = 0; a < acl_pkg::NAX; a++) begin : g_ax
      localparam logic [1:0] AXI = 2'(a);

      logic [CW-1:0] slp_ff;
      logic [CW-1:0] sln_ff;
      logic [CW-1:0] tol_ff;
      logic [CW-1:0] gval_ff;
      logic [CW-1:0] tval_ff;
      logic [31:0]   ctrl_ff;
      logic [5:0]    sts_ff;
      logic          oos_q_ff;
      logic          gen_q_ff;
      logic          imm_ff;
      logic          dec_ff;
      logic          oreq_ff;
      logic          greq_ff;

      // ----------------------------------------
      // register writes
      // ----------------------------------------
      wire        sel_ax   = wr_stb & (ax == AXI);
      wire        w_ctl    = sel_ax & (rg == acl_pkg::R_CTRL);
      wire        w_sts    = sel_ax & (rg == acl_pkg::R_STS);
      wire        w_push   = sel_ax & (rg == acl_pkg::R_PUSH);
      wire [31:0] nxt_ctrl = mrg(ctrl_ff);
      wire [31:0] nxt_slp  = mrg(sx(slp_ff));
      wire [31:0] nxt_sln  = mrg(sx(sln_ff));
      wire [31:0] nxt_tol  = mrg(32'(tol_ff));
      wire [31:0] nxt_gval = mrg(sx(gval_ff));
      wire [31:0] nxt_tval = mrg(sx(tval_ff));
      wire [5:0]  clr      = w_sts ? (WB_DAT_IN[5:0] & {6{WB_SEL_IN[0]}}) : 6'h00;

      always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
         if (!RSTN_IN) begin
            slp_ff  <= '0;
            sln_ff  <= '0;
            tol_ff  <= '0;
            gval_ff <= '0;
            tval_ff <= '0;
            ctrl_ff <= acl_pkg::CTRL_RST;
         end else if (sel_ax) begin
            if (rg == acl_pkg::R_SLP) slp_ff <= nxt_slp[CW-1:0];
            if (rg == acl_pkg::R_SLN) sln_ff <= nxt_sln[CW-1:0];
            if (rg == acl_pkg::R_TOL) tol_ff <= nxt_tol[CW-1:0];
            if (rg == acl_pkg::R_GVAL) gval_ff <= nxt_gval[CW-1:0];
            if (rg == acl_pkg::R_TVAL) tval_ff <= nxt_tval[CW-1:0];
            if (rg == acl_pkg::R_CTRL) ctrl_ff <= nxt_ctrl;
         end
      end

      // ----------------------------------------
      // comparators 1 to 4
      // ----------------------------------------
      wire signed [31:0] cmd = sx(AXIS_CNT_IN[a][acl_pkg::CNT_CMD]);
      wire signed [31:0] err = sx(AXIS_CNT_IN[a][acl_pkg::CNT_ERR]);
      wire [31:0]        aer = err[31] ? 32'(-err) : 32'(err);
      wire p_hit = ctrl_ff[acl_pkg::C_SLP_EN] & (cmd >= sx(slp_ff));
      wire n_hit = ctrl_ff[acl_pkg::C_SLN_EN] & (cmd <= sx(sln_ff));
      wire oos   = ctrl_ff[acl_pkg::C_OOS_EN] & (aer > 32'(tol_ff));
      wire [1:0] gsrc = ctrl_ff[acl_pkg::C_GSRC +: 2];
      wire gen   = ctrl_ff[acl_pkg::C_GEN_EN]
                 & acl_pkg::acl_cmp(acl_pkg::acl_cmp_mode_t'(ctrl_ff[acl_pkg::C_GMODE +: 2]),
                                    sx(AXIS_CNT_IN[a][gsrc]), sx(gval_ff));
      wire o_rise = oos & ~oos_q_ff;
      wire g_rise = gen & ~gen_q_ff;
      wire stop   = p_hit | n_hit | (gen & ctrl_ff[acl_pkg::C_GEN_STOP]);
      wire [5:0] ev = {lat_ev[a], trg_ev[a], g_rise, o_rise, n_hit, p_hit};

      // stop stays asserted while the limit condition holds
      always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
         if (!RSTN_IN) begin
            oos_q_ff <= 1'b0;
            gen_q_ff <= 1'b0;
            imm_ff   <= 1'b0;
            dec_ff   <= 1'b0;
            oreq_ff  <= 1'b0;
            greq_ff  <= 1'b0;
            sts_ff   <= 6'h00;
         end else begin
            oos_q_ff <= oos;
            gen_q_ff <= gen;
            imm_ff   <= stop & ~ctrl_ff[acl_pkg::C_SL_DEC];
            dec_ff   <= stop & ctrl_ff[acl_pkg::C_SL_DEC];
            oreq_ff  <= o_rise;
            greq_ff  <= g_rise & ctrl_ff[acl_pkg::C_GEN_IRQ];
            sts_ff   <= (sts_ff & ~clr) | ev;
         end
      end

      assign STOP_IMM_OUT[a] = imm_ff;
      assign STOP_DEC_OUT[a] = dec_ff;
      assign OOS_REQ_OUT[a]  = oreq_ff;
      assign GEN_REQ_OUT[a]  = greq_ff;

      if (a < 2) begin : g_trg
         // ----------------------------------------
         // comparator 5 and its list
         // ----------------------------------------
         acl_mem_if #(.AW(AW), .DW(CW)) mif ();
         logic [AW:0]   wp_ff;
         logic [AW:0]   rp_ff;
         logic [CW-1:0] act_ff;
         logic          ld_ff;
         logic          thit_ff;
         logic          tout_ff;
         logic [PW-1:0] pcnt_ff;

         wire [AW:0]   cnt   = wp_ff - rp_ff;
         wire          empty = (cnt == '0);
         wire          full  = cnt[AW];
         wire          auto  = ctrl_ff[acl_pkg::C_AUTO];
         wire          start = w_ctl & nxt_ctrl[acl_pkg::C_AUTO] & ~auto;
         wire          flush = w_ctl & ~nxt_ctrl[acl_pkg::C_AUTO];
         wire          push  = w_push & ~full;
         wire [CW-1:0] cref  = auto ? act_ff : tval_ff;
         wire signed [31:0] fb = sx(AXIS_CNT_IN[a][acl_pkg::CNT_FB]);
         wire tcond = ctrl_ff[acl_pkg::C_TRIG_EN]
                    & acl_pkg::acl_cmp(acl_pkg::acl_cmp_mode_t'(ctrl_ff[acl_pkg::C_TMODE +: 2]),
                                       fb, sx(cref));
         // a load in flight holds off firing against the stale value
         wire fire   = tcond & ~thit_ff & ~ld_ff;
         wire pop    = auto & fire;
         wire rd_req = (start | pop) & ~empty;

         assign mif.we    = push;
         assign mif.waddr = wp_ff[AW-1:0];
         assign mif.wdata = WB_DAT_IN[CW-1:0];
         assign mif.re    = rd_req;
         assign mif.raddr = rp_ff[AW-1:0];

         acl_list_mem #(.AW(AW), .DW(CW)) u_list (
            .clk_in (CORE_CLK_IN),
            .mif    (mif)
         );

         always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               wp_ff <= '0;
               rp_ff <= '0;
            end else if (flush) begin
               wp_ff <= '0;
               rp_ff <= '0;
            end else begin
               wp_ff <= wp_ff + (AW+1)'(push);
               rp_ff <= rp_ff + (AW+1)'(rd_req);
            end
         end

         always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               act_ff  <= '0;
               ld_ff   <= 1'b0;
               thit_ff <= 1'b0;
            end else begin
               ld_ff   <= rd_req;
               thit_ff <= tcond & ~ld_ff;
               if (ld_ff) act_ff <= mif.rdata;
            end
         end

         // fixed-width pulse; a new fire restarts it
         always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               pcnt_ff <= '0;
               tout_ff <= 1'b0;
            end else begin
               pcnt_ff <= fire ? PULSE_LEN : pcnt_ff - PW'(pcnt_ff != '0);
               tout_ff <= fire | (pcnt_ff > PW'(1));
            end
         end

         assign trg_w[a]   = tout_ff;
         assign trg_ev[a]  = fire;
         assign act_w[a]   = cref;
         assign cnt_w[a]   = 16'(cnt);
         assign full_w[a]  = full;
         assign empty_w[a] = empty;
         assign lat_ev[a]  = 1'b0;
         assign lat_w[a]   = '0;
      end else begin : g_lat
         // ----------------------------------------
         // position latch
         // ----------------------------------------
         logic [1:0]                s1_ff;
         logic [1:0]                s2_ff;
         logic                      lv_q_ff;
         logic [3:0][CW-1:0]        cap_ff;

         // three cycles from pin to capture: two for sync, one for the edge
         wire lraw  = ctrl_ff[acl_pkg::C_LSRC] ? s2_ff[1] : s2_ff[0];
         wire lv    = ~(lraw ^ ctrl_ff[acl_pkg::C_LPOL]);
         wire ledge = lv & ~lv_q_ff;

         always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               s1_ff   <= 2'b00;
               s2_ff   <= 2'b00;
               lv_q_ff <= 1'b1;
               cap_ff  <= '0;
            end else begin
               s1_ff   <= {ORIGIN_SENSOR_INPUT_IN[a], lpin[a]};
               s2_ff   <= s1_ff;
               lv_q_ff <= lv;
               if (ledge) cap_ff <= AXIS_CNT_IN[a];
            end
         end

         assign trg_w[a]   = 1'b0;
         assign trg_ev[a]  = 1'b0;
         assign act_w[a]   = '0;
         assign cnt_w[a]   = 16'h0000;
         assign full_w[a]  = 1'b0;
         assign empty_w[a] = 1'b1;
         assign lat_ev[a]  = ledge;
         assign lat_w[a]   = cap_ff;
      end

      // ----------------------------------------
      // read mux
      // ----------------------------------------
      wire [31:0] sts_word = {cnt_w[a], 8'h00, full_w[a], empty_w[a], sts_ff};
      assign rd_w[a] =
         (rg == acl_pkg::R_SLP)  ? sx(slp_ff)  :
         (rg == acl_pkg::R_SLN)  ? sx(sln_ff)  :
         (rg == acl_pkg::R_TOL)  ? 32'(tol_ff) :
         (rg == acl_pkg::R_GVAL) ? sx(gval_ff) :
         (rg == acl_pkg::R_CTRL) ? ctrl_ff     :
         (rg == acl_pkg::R_TVAL) ? sx(tval_ff) :
         (rg == acl_pkg::R_ACT)  ? sx(act_w[a]) :
         (rg == acl_pkg::R_STS)  ? sts_word    :
         (rg >= acl_pkg::R_LAT0) ? sx(lat_w[a][rg[1:0]]) :
         32'h0000_0000;
   end

endmodule

// *** acl_pkg.sv ***
package acl_pkg;

   // ----------------------------------------
   // sizes and timing
   // ----------------------------------------
   localparam int NAX  = 4;
   localparam int NCNT = 4;
   localparam int CLK_HZ = 50_000_000;
   localparam int TRIG_PULSE_US = 30;
   localparam int TRIG_PULSE_CYC = TRIG_PULSE_US * (CLK_HZ / 1_000_000);
   // host appends this far-off value after a generated list
   localparam logic [27:0] LIST_DUMMY = 28'h7ffffff;

   // ----------------------------------------
   // counter numbers within an axis
   // ----------------------------------------
   localparam int CNT_CMD = 0;
   localparam int CNT_FB  = 1;
   localparam int CNT_ERR = 2;

   // ----------------------------------------
   // wishbone byte address layout
   // ----------------------------------------
   localparam int AX_LSB = 6;
   localparam int RG_LSB = 2;

   // register index inside one axis block
   localparam logic [3:0] R_SLP  = 4'h0;
   localparam logic [3:0] R_SLN  = 4'h1;
   localparam logic [3:0] R_TOL  = 4'h2;
   localparam logic [3:0] R_GVAL = 4'h3;
   localparam logic [3:0] R_CTRL = 4'h4;
   localparam logic [3:0] R_TVAL = 4'h5;
   localparam logic [3:0] R_ACT  = 4'h6;
   localparam logic [3:0] R_PUSH = 4'h7;
   localparam logic [3:0] R_STS  = 4'h8;
   localparam logic [3:0] R_LAT0 = 4'hc;

   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int C_SLP_EN   = 0;
   localparam int C_SLN_EN   = 1;
   localparam int C_SL_DEC   = 2;
   localparam int C_OOS_EN   = 3;
   localparam int C_GEN_EN   = 4;
   localparam int C_GEN_IRQ  = 5;
   localparam int C_GEN_STOP = 6;
   localparam int C_GSRC     = 8;
   localparam int C_GMODE    = 10;
   localparam int C_TRIG_EN  = 12;
   localparam int C_TMODE    = 13;
   localparam int C_AUTO     = 15;
   localparam int C_LPOL     = 16;
   localparam int C_LSRC     = 17;
   localparam logic [31:0] CTRL_RST = 32'h0000_0020;

   // ----------------------------------------
   // status fields
   // ----------------------------------------
   localparam int S_EMPTY = 6;
   localparam int S_FULL  = 7;
   localparam int S_CNT   = 16;

   typedef enum logic [1:0] {CM_GT, CM_EQ, CM_LT} acl_cmp_mode_t;

   function automatic logic acl_cmp(input acl_cmp_mode_t m,
                                    input logic signed [31:0] v,
                                    input logic signed [31:0] r);
      case (m)
         CM_GT:   acl_cmp = v > r;
         CM_EQ:   acl_cmp = v == r;
         CM_LT:   acl_cmp = v < r;
         default: acl_cmp = 1'b0;
      endcase
   endfunction

endpackage

// *** acl_mem_if.sv ***
`timescale 1ns/100ps
interface acl_mem_if #(parameter int AW = 6, parameter int DW = 28);
   logic          we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic          re;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctl (output we, waddr, wdata, re, raddr, input rdata);
   modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// *** acl_list_mem.sv ***
`timescale 1ns/100ps
module acl_list_mem #(
   parameter int AW = 6,
   parameter int DW = 28
) (
   input wire logic clk_in,
   acl_mem_if.mem   mif
);

   // ----------------------------------------
   // comparison list storage
   // ----------------------------------------
   logic [DW-1:0] store_ff [0:(1<<AW)-1];
   logic [DW-1:0] rdata_ff;

   always_ff @(posedge clk_in) begin
      if (mif.we) begin
         store_ff[mif.waddr] <= mif.wdata;
      end
   end

   // registered read, one cycle after re
   always_ff @(posedge clk_in) begin
      if (mif.re) begin
         rdata_ff <= store_ff[mif.raddr];
      end
   end

   assign mif.rdata = rdata_ff;

endmodule

// *** acl_properties.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// port checker
// ----------------------------------------
module acl_properties #(
   parameter int CW = 28
) (
   input wire logic                    CORE_CLK_IN,
   input wire logic                    RSTN_IN,
   input wire logic                    WB_CYC_IN,
   input wire logic                    WB_STB_IN,
   input wire logic                    WB_ACK_OUT,
   input wire logic [3:0][3:0][CW-1:0] AXIS_CNT_IN,
   input wire logic                    TRIGGER_OUT_AXIS_A_OUT,
   input wire logic                    TRIGGER_OUT_AXIS_B_OUT,
   input wire logic [3:0]              STOP_IMM_OUT,
   input wire logic [3:0]              STOP_DEC_OUT,
   input wire logic [3:0]              OOS_REQ_OUT,
   input wire logic [3:0]              GEN_REQ_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // saturates so a long refire chain cannot wrap to a short count
   logic [11:0] run_ff;
   wire  [11:0] nxt_run = !TRIGGER_OUT_AXIS_A_OUT ? 12'h000 : run_ff + {11'h000, run_ff != 12'hfff};
   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) run_ff <= 12'h000;
      else run_ff <= nxt_run;
   end
   ack_one_cycle_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack held longer than one cycle");
   ack_has_req_a: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN & WB_STB_IN))
      else $error("ack without a request");
   oos_single_a: assert property ((OOS_REQ_OUT & $past(OOS_REQ_OUT)) == 4'h0)
      else $error("out-of-step request wider than one cycle");
   gen_single_a: assert property ((GEN_REQ_OUT & $past(GEN_REQ_OUT)) == 4'h0)
      else $error("general request wider than one cycle");
   stop_kind_a: assert property ((STOP_IMM_OUT & STOP_DEC_OUT) == 4'h0)
      else $error("both stop kinds on one axis");
   oos_cause_a: assert property (OOS_REQ_OUT[2] |-> ($past(AXIS_CNT_IN[2][2]) != '0 ||
      $past(AXIS_CNT_IN[2][2], 2) != '0 || $past(AXIS_CNT_IN[2][2], 3) != '0))
      else $error("out-of-step request with zero error");
   trig_width_a: assert property ($fell(TRIGGER_OUT_AXIS_A_OUT) |-> run_ff >= acl_pkg::TRIG_PULSE_CYC)
      else $error("trigger pulse too short");
   trig_hold_a: assert property ($rose(TRIGGER_OUT_AXIS_B_OUT) |=> TRIGGER_OUT_AXIS_B_OUT [*8])
      else $error("trigger pulse dropped early");
   cover property (OOS_REQ_OUT[2]);
   cover property ($rose(TRIGGER_OUT_AXIS_B_OUT));
   cover property (STOP_DEC_OUT[1]);
endmodule
bind acl_top acl_properties #(.CW(CW)) chk_u (.CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN),
   .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT), .AXIS_CNT_IN(AXIS_CNT_IN),
   .TRIGGER_OUT_AXIS_A_OUT(TRIGGER_OUT_AXIS_A_OUT), .TRIGGER_OUT_AXIS_B_OUT(TRIGGER_OUT_AXIS_B_OUT),
   .STOP_IMM_OUT(STOP_IMM_OUT), .STOP_DEC_OUT(STOP_DEC_OUT), .OOS_REQ_OUT(OOS_REQ_OUT),
   .GEN_REQ_OUT(GEN_REQ_OUT));

// *** acl_far_end.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// latch source and trigger sink
// ----------------------------------------
module acl_far_end (
   input  wire logic       clk_in,
   input  wire logic [1:0] lvl_in,
   input  wire logic       trig_a_in,
   input  wire logic       trig_b_in,
   output wire logic       latch_c_out,
   output wire logic       latch_d_out,
   output wire logic [3:0] org_out
);
   int         hits_a = 0;
   int         hits_b = 0;
   logic [1:0] trig_ff = 2'b00;
   logic [3:0] act_ff = 4'h0;
   // pins rest at the inactive level; origin sensors rest low
   assign latch_c_out = ~(lvl_in[0] ^ act_ff[0]);
   assign latch_d_out = ~(lvl_in[1] ^ act_ff[1]);
   assign org_out = {act_ff[3:2], 2'b00};
   // short pulse: only a few clocks, no kinder than a real sensor
   task fire(input int ch);
      @(posedge clk_in);
      act_ff[ch] <= 1'b1;
      repeat (4) @(posedge clk_in);
      act_ff[ch] <= 1'b0;
   endtask
   always @(posedge clk_in) begin
      trig_ff <= {trig_b_in, trig_a_in};
      if (trig_a_in === 1'b1 && trig_ff[0] === 1'b0) hits_a++;
      if (trig_b_in === 1'b1 && trig_ff[1] === 1'b0) hits_b++;
   end
endmodule

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
   // ----------------------------------------
   // stimulus and wiring
   // ----------------------------------------
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  cyc = 1'b0;
   logic                  we = 1'b0;
   logic [7:0]            adr = 8'h00;
   logic [31:0]           wdat = 32'h0;
   logic [31:0]           rdat;
   logic [3:0][3:0][27:0] cnt = '0;
   logic [1:0]            lvl = 2'b01;
   wire logic [31:0]      dout;
   wire logic             ack, ta, tb, lc, ld;
   wire logic [3:0]       origin_sensor_input, simm, sdec, oos, gen;
   int                    errors = 0;
   int                    checks = 0;
   int                    oos_n = 0;
   int                    gen_n = 0;
   initial forever #10 clk = ~clk;
   acl_top dut_u (.CORE_CLK_IN(clk), .RSTN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack),
      .AXIS_CNT_IN(cnt), .LATCH_IN_AXIS_C_IN(lc), .LATCH_IN_AXIS_D_IN(ld), .ORIGIN_SENSOR_INPUT_IN(origin_sensor_input),
      .TRIGGER_OUT_AXIS_A_OUT(ta), .TRIGGER_OUT_AXIS_B_OUT(tb), .STOP_IMM_OUT(simm),
      .STOP_DEC_OUT(sdec), .OOS_REQ_OUT(oos), .GEN_REQ_OUT(gen));
   acl_far_end far_u (.clk_in(clk), .lvl_in(lvl), .trig_a_in(ta), .trig_b_in(tb),
      .latch_c_out(lc), .latch_d_out(ld), .org_out(origin_sensor_input));
   always @(posedge clk) begin
      oos_n <= oos_n + oos[2];
      gen_n <= gen_n + gen[3];
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until ack is sampled high, then released
   task automatic wb(input logic w, input logic [1:0] ax, input logic [3:0] ix, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= {ax, ix, 2'b00};
      wdat <= d;
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n == 50) begin
         errors++;
         wrap_up();
      end
      rdat = dout;
      cyc <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] ax, input logic [3:0] ix, input logic [31:0] exp);
      wb(1'b0, ax, ix, 32'h0);
      chk(rdat, exp);
   endtask
   // waits out the long trigger pulse so the next fire shows a fresh edge
   task automatic settle();
      int n;
      n = 0;
      while ((ta | tb) !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n == 2000) begin
         errors++;
         wrap_up();
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic lat(input logic [1:0] ax, input logic [31:0] b);
      for (int k = 0; k < 4; k++) rd(ax, 4'(acl_pkg::R_LAT0 + k), b + k);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(2'h0, acl_pkg::R_CTRL, acl_pkg::CTRL_RST);
      rd(2'h1, 4'h9, 32'h0);
      wb(1'b1, 2'h1, acl_pkg::R_SLP, 32'h64);
      wb(1'b1, 2'h1, acl_pkg::R_SLN, 32'hfffffffb);
      rd(2'h1, acl_pkg::R_SLN, 32'hfffffffb);
      wb(1'b1, 2'h1, acl_pkg::R_CTRL, 32'h3);
      repeat (4) @(posedge clk);
      chk({24'h0, simm, sdec}, 32'h0);
      cnt[1][0] <= 28'h64;
      repeat (4) @(posedge clk);
      chk({24'h0, simm, sdec}, 32'h20);
      wb(1'b1, 2'h1, acl_pkg::R_CTRL, 32'h7);
      cnt[1][0] <= 28'hffffffb;
      repeat (4) @(posedge clk);
      chk({24'h0, simm, sdec}, 32'h02);
      cnt[2][2] <= 28'h0b;
      wb(1'b1, 2'h2, acl_pkg::R_TOL, 32'ha);
      repeat (5) @(posedge clk);
      chk(oos_n, 32'h0);
      wb(1'b1, 2'h2, acl_pkg::R_CTRL, 32'h8);
      cnt[2][2] <= 28'h0a;
      repeat (4) @(posedge clk);
      cnt[2][2] <= 28'hffffff4;
      repeat (4) @(posedge clk);
      chk(oos_n, 32'h2);
      wb(1'b1, 2'h3, acl_pkg::R_GVAL, 32'h32);
      wb(1'b1, 2'h3, acl_pkg::R_CTRL, 32'h730);
      cnt[3][3] <= 28'h32;
      repeat (4) @(posedge clk);
      wb(1'b1, 2'h3, acl_pkg::R_CTRL, 32'h330);
      cnt[3][3] <= 28'h33;
      repeat (4) @(posedge clk);
      chk(gen_n, 32'h2);
      wb(1'b1, 2'h0, acl_pkg::R_TVAL, 32'h14);
      rd(2'h0, acl_pkg::R_ACT, 32'h14);
      for (int m = 0; m < 3; m++) begin
         cnt[0][1] <= (m == 2) ? 28'h28 : 28'h0;
         wb(1'b1, 2'h0, acl_pkg::R_CTRL, 32'h1000 | (m << 13));
         cnt[0][1] <= 28'(21 - m);
         repeat (4) @(posedge clk);
         chk(far_u.hits_a, m + 1);
         settle();
      end
      wb(1'b1, 2'h1, acl_pkg::R_TVAL, 32'h5);
      wb(1'b1, 2'h1, acl_pkg::R_CTRL, 32'h3000);
      for (logic [31:0] v = 32'h1e; v <= 32'h20; v++) wb(1'b1, 2'h1, acl_pkg::R_PUSH, v);
      wb(1'b1, 2'h1, acl_pkg::R_PUSH, {4'h0, acl_pkg::LIST_DUMMY});
      rd(2'h1, acl_pkg::R_STS, 32'h00040003);
      wb(1'b1, 2'h1, acl_pkg::R_CTRL, 32'hb000);
      repeat (3) @(posedge clk);
      rd(2'h1, acl_pkg::R_ACT, 32'h1e);
      cnt[1][1] <= 28'h5;
      repeat (4) @(posedge clk);
      chk(far_u.hits_b, 32'h0);
      for (int v = 0; v < 3; v++) begin
         cnt[1][1] <= 28'(30 + v);
         repeat (4) @(posedge clk);
         rd(2'h1, acl_pkg::R_ACT, (v < 2) ? 32'(31 + v) : {4'h0, acl_pkg::LIST_DUMMY});
         settle();
      end
      chk(far_u.hits_b, 32'h3);
      chk(far_u.hits_a, 32'h3);
      cnt[2] <= {28'h14, 28'h13, 28'h12, 28'h11};
      wb(1'b1, 2'h2, acl_pkg::R_CTRL, 32'h10000);
      far_u.fire(0);
      cnt[2] <= {4{28'h1}};
      lat(2'h2, 32'h11);
      cnt[3] <= {28'h4, 28'h3, 28'h2, 28'h1};
      wb(1'b1, 2'h3, acl_pkg::R_CTRL, 32'h0);
      far_u.fire(1);
      cnt[3] <= '0;
      lat(2'h3, 32'h1);
      cnt[3] <= {28'h8, 28'h7, 28'h6, 28'h5};
      wb(1'b1, 2'h3, acl_pkg::R_CTRL, 32'h30000);
      far_u.fire(3);
      cnt[3] <= '0;
      lat(2'h3, 32'h5);
      rd(2'h0, acl_pkg::R_LAT0, 32'h0);
      rd(2'h3, acl_pkg::R_STS, 32'h68);
      wb(1'b1, 2'h3, acl_pkg::R_STS, 32'h3f);
      rd(2'h3, acl_pkg::R_STS, 32'h40);
      wrap_up();
   end
endmodule
